// ---- src/pmcs_pkg.sv ----
package pmcs_pkg;
	// Register offsets on the management serial port
	localparam logic [4:0] PHY_CONTROL_ADDR = 5'h00;
	localparam logic [4:0] PHY_BASIC_STATUS_ADDR = 5'h01;
	localparam logic [4:0] PHY_IDENTIFIER_HIGH_ADDR = 5'h02;
	// Control field positions
	localparam int CTL_RESET_BIT = 15;
	localparam int CTL_LOOPBACK_BIT = 14;
	localparam int CTL_SPEED_BIT = 13;
	localparam int CTL_NEG_ENABLE_BIT = 12;
	localparam int CTL_POWERDOWN_BIT = 11;
	localparam int CTL_IF_DISABLE_BIT = 10;
	localparam int CTL_NEG_RESTART_BIT = 9;
	localparam int CTL_DUPLEX_BIT = 8;
	localparam int CTL_COLTEST_BIT = 7;
	// Control reset values
	localparam logic CTL_LOOPBACK_RST = 1'b0;
	localparam logic CTL_SPEED_RST = 1'b1;
	localparam logic CTL_NEG_ENABLE_RST = 1'b1;
	localparam logic CTL_POWERDOWN_RST = 1'b0;
	localparam logic CTL_DUPLEX_RST = 1'b0;
	localparam logic CTL_COLTEST_RST = 1'b0;
	localparam logic [4:0] IF_DISABLE_STRAP = 5'h1f;
	// Status field positions
	localparam int STS_FOURPAIR_BIT = 15;
	localparam int STS_FAST_FULL_BIT = 14;
	localparam int STS_FAST_HALF_BIT = 13;
	localparam int STS_SLOW_FULL_BIT = 12;
	localparam int STS_SLOW_HALF_BIT = 11;
	localparam int STS_PREAMBLE_SKIP_BIT = 6;
	localparam int STS_NEG_ACK_BIT = 5;
	localparam int STS_REMOTE_FAULT_BIT = 4;
	localparam int STS_NEG_ABILITY_BIT = 3;
	localparam int STS_LINK_BIT = 2;
	localparam int STS_JABBER_BIT = 1;
	localparam int STS_EXT_REGS_BIT = 0;
	// Organisation identifier bits 3..18; value is arbitrary
	localparam logic [15:0] ORG_ID_HIGH = 16'h5a5a;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SOFT_RESET_TIME_NS = 1000;
	localparam int RESTART_TIME_NS = 500;
	localparam int SOFT_RESET_CYCLES =
		(SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESTART_CYCLES =
		(RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Serial frame
	localparam logic [5:0] PREAMBLE_ONES = 6'd32;
	localparam logic [1:0] OP_READ = 2'b10;
	localparam logic [1:0] OP_WRITE = 2'b01;
endpackage : pmcs_pkg

// ---- src/pmcs_acc_if.sv ----
`timescale 1ns/1ps
interface pmcs_acc_if;
	logic [4:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic [15:0] rdata;
	modport engine (output addr, output wdata, output wr, output rd,
		input rdata);
	modport bank (input addr, input wdata, input wr, input rd,
		output rdata);
endinterface : pmcs_acc_if

// ---- src/pmcs_serial_engine.sv ----
`timescale 1ns/1ps
module pmcs_serial_engine
	import pmcs_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Serial pins
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	// Own address
	input wire logic [4:0] phy_addr_i,
	// Register access
	pmcs_acc_if.engine acc
);
	typedef enum {S_PRE, S_START, S_HDR, S_TA, S_DATA} pmcs_state_e;
	pmcs_state_e state_reg;
	logic mdc_meta_reg, mdc_sync_reg, mdc_prev_reg;
	logic mdio_meta_reg, mdio_sync_reg;
	logic [5:0] pre_cnt_reg;
	logic [3:0] cnt_reg;
	logic [15:0] shift_reg;
	logic read_reg, match_reg;
	logic [4:0] addr_reg;
	logic [15:0] wdata_reg;
	logic wr_reg, rd_reg;
	logic rise;
	logic [11:0] hdr;

	// Both pins cross through two flops with equal delay
	always_ff @(posedge ref_clk_i)
	begin
		mdc_meta_reg <= mdc_i;
		mdc_sync_reg <= mdc_meta_reg;
		mdc_prev_reg <= mdc_sync_reg;
		mdio_meta_reg <= mdio_i;
		mdio_sync_reg <= mdio_meta_reg;
	end

	assign rise = mdc_sync_reg & ~mdc_prev_reg;
	assign hdr = {shift_reg[10:0], mdio_sync_reg};

	always_ff @(posedge ref_clk_i)
	begin
		rd_reg <= 1'b0;
		wr_reg <= 1'b0;
		if (reset_i)
		begin
			state_reg <= S_PRE;
			pre_cnt_reg <= 6'h00;
			cnt_reg <= 4'h0;
			shift_reg <= 16'h0000;
			read_reg <= 1'b0;
			match_reg <= 1'b0;
			addr_reg <= 5'h00;
			wdata_reg <= 16'h0000;
			mdio_o <= 1'b0;
			mdio_oe_o <= 1'b0;
		end
		else if (rise)
		begin
			unique case (state_reg)
				S_PRE:
				begin
					// Frames without the full preamble are dropped
					if (mdio_sync_reg)
					begin
						if (pre_cnt_reg != PREAMBLE_ONES)
							pre_cnt_reg <= pre_cnt_reg + 6'h01;
					end
					else
					begin
						if (pre_cnt_reg == PREAMBLE_ONES)
							state_reg <= S_START;
						pre_cnt_reg <= 6'h00;
					end
				end
				S_START:
				begin
					state_reg <= mdio_sync_reg ? S_HDR : S_PRE;
					cnt_reg <= 4'h0;
				end
				S_HDR:
				begin
					shift_reg <= {shift_reg[14:0], mdio_sync_reg};
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == 4'hb)
					begin
						cnt_reg <= 4'h0;
						addr_reg <= hdr[4:0];
						match_reg <= (hdr[9:5] == phy_addr_i);
						read_reg <= (hdr[11:10] == OP_READ);
						if (hdr[11:10] == OP_READ ||
							hdr[11:10] == OP_WRITE)
							state_reg <= S_TA;
						else
							state_reg <= S_PRE;
						if (hdr[11:10] == OP_READ && hdr[9:5] == phy_addr_i)
							rd_reg <= 1'b1;
					end
				end
				S_TA:
				begin
					cnt_reg <= cnt_reg + 4'h1;
					if (cnt_reg == 4'h0)
					begin
						if (read_reg && match_reg)
						begin
							mdio_o <= 1'b0;
							mdio_oe_o <= 1'b1;
						end
					end
					else
					begin
						cnt_reg <= 4'h0;
						state_reg <= S_DATA;
						if (read_reg)
						begin
							mdio_o <= shift_reg[15];
							shift_reg <= {shift_reg[14:0], 1'b0};
						end
					end
				end
				S_DATA:
				begin
					cnt_reg <= cnt_reg + 4'h1;
					if (read_reg)
					begin
						mdio_o <= shift_reg[15];
						shift_reg <= {shift_reg[14:0], 1'b0};
					end
					else
						shift_reg <= {shift_reg[14:0], mdio_sync_reg};
					if (cnt_reg == 4'hf)
					begin
						state_reg <= S_PRE;
						mdio_oe_o <= 1'b0;
						mdio_o <= 1'b0;
						if (!read_reg && match_reg)
						begin
							wr_reg <= 1'b1;
							wdata_reg <= {shift_reg[14:0], mdio_sync_reg};
						end
					end
				end
			endcase
		end
		// Capture with the latch reload so a latched event is not lost
		else if (rd_reg)
			shift_reg <= acc.rdata;
	end

	assign acc.addr = addr_reg;
	assign acc.wdata = wdata_reg;
	assign acc.wr = wr_reg;
	assign acc.rd = rd_reg;
endmodule : pmcs_serial_engine

// ---- src/pmcs_mgmt_regs.sv ----
`timescale 1ns/1ps
module pmcs_mgmt_regs
	import pmcs_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Management serial port
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_o,
	// Address straps
	input wire logic [4:0] phy_address_straps_i,
	// Events from transceiver units
	input wire logic link_fail_i,
	input wire logic jabber_i,
	input wire logic interrupt_detect_i,
	input wire logic partner_remote_fault_i,
	input wire logic negotiation_ack_done_i,
	// Controls to transceiver units
	output logic transceiver_reset_o,
	output logic loopback_enable_o,
	output logic speed_100_o,
	output logic negotiation_enable_o,
	output logic powerdown_enable_o,
	output logic controller_if_disable_o,
	output logic negotiation_restart_o,
	output logic duplex_select_o,
	output logic collision_test_enable_o
);
	pmcs_acc_if acc ();

	logic [4:0] strap_meta_reg, strap_sync_reg;
	logic [4:0] phy_addr_reg;
	logic defaults_pending_reg;
	logic soft_reset_reg;
	logic [15:0] soft_cnt_reg;
	logic restart_reg;
	logic [15:0] restart_cnt_reg;
	logic loopback_reg, speed_reg, neg_enable_reg, powerdown_reg;
	logic if_disable_reg, duplex_reg, coltest_reg;
	logic remote_fault_latch_reg, jabber_latch_reg, link_latch_reg;
	logic ctl_write, status_read, link_now, remote_now;
	logic [15:0] control_value, status_value;

	// Straps are pins: two flops before use
	always_ff @(posedge ref_clk_i)
	begin
		strap_meta_reg <= phy_address_straps_i;
		strap_sync_reg <= strap_meta_reg;
	end

	assign ctl_write = acc.wr && acc.addr == PHY_CONTROL_ADDR;
	assign status_read = acc.rd && acc.addr == PHY_BASIC_STATUS_ADDR;

	// Straps are caught a cycle after reset so the sync chain has settled
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			defaults_pending_reg <= 1'b1;
		else if (soft_reset_reg && soft_cnt_reg == 16'h0001)
			defaults_pending_reg <= 1'b1;
		else
			defaults_pending_reg <= 1'b0;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			phy_addr_reg <= 5'h00;
		else if (defaults_pending_reg)
			phy_addr_reg <= strap_sync_reg;
	end

	// Soft reset: bit reads one for the whole reset interval
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			soft_reset_reg <= 1'b0;
			soft_cnt_reg <= 16'h0000;
		end
		else if (soft_reset_reg)
		begin
			soft_cnt_reg <= soft_cnt_reg - 16'h0001;
			if (soft_cnt_reg == 16'h0001)
				soft_reset_reg <= 1'b0;
		end
		else if (ctl_write && acc.wdata[CTL_RESET_BIT])
		begin
			soft_reset_reg <= 1'b1;
			soft_cnt_reg <= 16'(SOFT_RESET_CYCLES);
		end
	end

	// Restart runs a fixed interval, then the bit clears itself
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i || soft_reset_reg || defaults_pending_reg)
		begin
			restart_reg <= 1'b0;
			restart_cnt_reg <= 16'h0000;
		end
		else if (restart_reg)
		begin
			restart_cnt_reg <= restart_cnt_reg - 16'h0001;
			if (restart_cnt_reg == 16'h0001)
				restart_reg <= 1'b0;
		end
		else if (ctl_write && acc.wdata[CTL_NEG_RESTART_BIT])
		begin
			restart_reg <= 1'b1;
			restart_cnt_reg <= 16'(RESTART_CYCLES);
		end
	end

	// Plain control fields; writes during a soft reset are ignored
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i || defaults_pending_reg)
		begin
			loopback_reg <= CTL_LOOPBACK_RST;
			speed_reg <= CTL_SPEED_RST;
			neg_enable_reg <= CTL_NEG_ENABLE_RST;
			powerdown_reg <= CTL_POWERDOWN_RST;
			duplex_reg <= CTL_DUPLEX_RST;
			coltest_reg <= CTL_COLTEST_RST;
			if_disable_reg <= defaults_pending_reg &&
				strap_sync_reg == IF_DISABLE_STRAP;
		end
		else if (ctl_write && !soft_reset_reg &&
			!acc.wdata[CTL_RESET_BIT])
		begin
			loopback_reg <= acc.wdata[CTL_LOOPBACK_BIT];
			speed_reg <= acc.wdata[CTL_SPEED_BIT];
			neg_enable_reg <= acc.wdata[CTL_NEG_ENABLE_BIT];
			powerdown_reg <= acc.wdata[CTL_POWERDOWN_BIT];
			if_disable_reg <= acc.wdata[CTL_IF_DISABLE_BIT];
			duplex_reg <= acc.wdata[CTL_DUPLEX_BIT];
			coltest_reg <= acc.wdata[CTL_COLTEST_BIT];
		end
	end

	assign link_now = ~link_fail_i;
	assign remote_now = interrupt_detect_i | partner_remote_fault_i;

	// Latched bits: an event in the read cycle wins over the reload
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i || soft_reset_reg)
		begin
			remote_fault_latch_reg <= 1'b0;
			jabber_latch_reg <= 1'b0;
			link_latch_reg <= 1'b0;
		end
		else
		begin
			remote_fault_latch_reg <= (remote_fault_latch_reg &
				~status_read) | remote_now;
			jabber_latch_reg <= (jabber_latch_reg & ~status_read) |
				jabber_i;
			link_latch_reg <= (link_latch_reg | status_read) &
				link_now;
		end
	end

	always_comb
	begin
		control_value = 16'h0000;
		control_value[CTL_RESET_BIT] = soft_reset_reg;
		control_value[CTL_LOOPBACK_BIT] = loopback_reg;
		control_value[CTL_SPEED_BIT] = speed_reg;
		control_value[CTL_NEG_ENABLE_BIT] = neg_enable_reg;
		control_value[CTL_POWERDOWN_BIT] = powerdown_reg;
		control_value[CTL_IF_DISABLE_BIT] = if_disable_reg;
		control_value[CTL_NEG_RESTART_BIT] = restart_reg;
		control_value[CTL_DUPLEX_BIT] = duplex_reg;
		control_value[CTL_COLTEST_BIT] = coltest_reg;
	end

	always_comb
	begin
		status_value = 16'h0000;
		status_value[STS_FOURPAIR_BIT] = 1'b0;
		status_value[STS_FAST_FULL_BIT] = 1'b1;
		status_value[STS_FAST_HALF_BIT] = 1'b1;
		status_value[STS_SLOW_FULL_BIT] = 1'b1;
		status_value[STS_SLOW_HALF_BIT] = 1'b1;
		status_value[STS_PREAMBLE_SKIP_BIT] = 1'b0;
		status_value[STS_NEG_ACK_BIT] = negotiation_ack_done_i &
			~soft_reset_reg;
		status_value[STS_REMOTE_FAULT_BIT] = remote_fault_latch_reg |
			remote_now;
		status_value[STS_NEG_ABILITY_BIT] = 1'b1;
		status_value[STS_LINK_BIT] = link_latch_reg & link_now;
		status_value[STS_JABBER_BIT] = jabber_latch_reg | jabber_i;
		status_value[STS_EXT_REGS_BIT] = 1'b1;
	end

	// Unmapped reads return zero; writes outside control are dropped
	always_comb
	begin
		unique case (acc.addr)
			PHY_CONTROL_ADDR: acc.rdata = control_value;
			PHY_BASIC_STATUS_ADDR: acc.rdata = status_value;
			PHY_IDENTIFIER_HIGH_ADDR: acc.rdata = ORG_ID_HIGH;
			default: acc.rdata = 16'h0000;
		endcase
	end

	pmcs_serial_engine u_engine (
		.ref_clk_i(ref_clk_i),
		.reset_i(reset_i),
		.mdc_i(mdc_i),
		.mdio_i(mdio_i),
		.mdio_o(mdio_o),
		.mdio_oe_o(mdio_oe_o),
		.phy_addr_i(phy_addr_reg),
		.acc(acc.engine)
	);

	assign transceiver_reset_o = soft_reset_reg;
	assign loopback_enable_o = loopback_reg;
	assign speed_100_o = speed_reg;
	assign negotiation_enable_o = neg_enable_reg;
	assign powerdown_enable_o = powerdown_reg;
	assign controller_if_disable_o = if_disable_reg;
	assign negotiation_restart_o = restart_reg;
	assign duplex_select_o = duplex_reg;
	assign collision_test_enable_o = coltest_reg;
endmodule : pmcs_mgmt_regs

// ---- verification/pmcs_mgmt_regs_asserts.sv ----
`timescale 1ns/1ps
module pmcs_mgmt_regs_asserts
	import pmcs_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic reset_i,
	// Serial pins and straps
	input wire logic mdio_o,
	input wire logic mdio_oe_o,
	input wire logic [4:0] phy_address_straps_i,
	// Controls
	input wire logic transceiver_reset_o,
	input wire logic loopback_enable_o,
	input wire logic speed_100_o,
	input wire logic negotiation_enable_o,
	input wire logic powerdown_enable_o,
	input wire logic controller_if_disable_o,
	input wire logic negotiation_restart_o,
	input wire logic duplex_select_o,
	input wire logic collision_test_enable_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	logic [7:0] srst_cnt_reg;
	logic [7:0] rstrt_cnt_reg;
	logic [7:0] oe_cnt_reg;
	logic dflt;
	assign dflt = speed_100_o && negotiation_enable_o && !loopback_enable_o
		&& !powerdown_enable_o && !duplex_select_o
		&& !collision_test_enable_o && !negotiation_restart_o;
	always_ff @(posedge ref_clk_i)
		srst_cnt_reg <= transceiver_reset_o ? srst_cnt_reg + 8'h01 : 8'h00;
	always_ff @(posedge ref_clk_i)
		rstrt_cnt_reg <= negotiation_restart_o ? rstrt_cnt_reg + 8'h01 : 8'h00;
	always_ff @(posedge ref_clk_i)
		oe_cnt_reg <= mdio_oe_o ? oe_cnt_reg + 8'h01 : 8'h00;
	AST_RST_DEFAULTS: assert property ($fell(reset_i) |=> dflt)
		else $error("control defaults missing after reset");
	AST_STRAP_DISABLE: assert property ($fell(reset_i) |=>
		controller_if_disable_o == (phy_address_straps_i == IF_DISABLE_STRAP))
		else $error("interface disable default wrong for straps");
	AST_SRST_LEN: assert property ($fell(transceiver_reset_o) |->
		srst_cnt_reg == SOFT_RESET_CYCLES)
		else $error("soft reset length wrong");
	AST_SRST_RELOAD: assert property ($fell(transceiver_reset_o) |->
		##[0:2] dflt)
		else $error("defaults not reloaded after soft reset");
	AST_SRST_HOLD: assert property (transceiver_reset_o &&
		$past(transceiver_reset_o) |-> $stable(loopback_enable_o)
		&& $stable(duplex_select_o) && $stable(speed_100_o))
		else $error("controls moved during soft reset");
	AST_RESTART_LEN: assert property ($fell(negotiation_restart_o) &&
		!transceiver_reset_o |-> rstrt_cnt_reg == RESTART_CYCLES)
		else $error("restart did not clear after its run");
	AST_TA_ZERO: assert property ($rose(mdio_oe_o) |-> (!mdio_o) [*6])
		else $error("turnaround bit not zero");
	// Span fits the 80 ns management clock of the bench only
	AST_OE_SPAN: assert property ($fell(mdio_oe_o) |->
		oe_cnt_reg >= 8'd130 && oe_cnt_reg <= 8'd142)
		else $error("read drive span not seventeen bit times");
	cover property ($fell(transceiver_reset_o));
	cover property ($fell(negotiation_restart_o));
	cover property ($fell(mdio_oe_o));
endmodule : pmcs_mgmt_regs_asserts

bind pmcs_mgmt_regs pmcs_mgmt_regs_asserts u_chk (.*);

// ---- verification/pmcs_mgmt_master.sv ----
`timescale 1ns/1ps
module pmcs_mgmt_master
	import pmcs_pkg::*;
(
	// Clock
	input wire logic ref_clk_i,
	// Serial line
	input wire logic line_i,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_o
);
	// Clock stands low between frames
	initial
	begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_o = 1'b0;
	end
	task automatic bit_cycle(input logic b, input logic drv, output logic s);
		@(posedge ref_clk_i);
		mdc_o <= 1'b0;
		mdio_o <= b;
		mdio_oe_o <= drv;
		repeat (4) @(posedge ref_clk_i);
		s = line_i;
		mdc_o <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
	endtask : bit_cycle
	task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd, input int pre,
		output logic [15:0] rd);
		logic [31:0] w;
		logic s;
		w = {2'b01, op, pa, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = 0; i < pre; i++)
			bit_cycle(1'b1, 1'b1, s);
		// Line released from turnaround on when reading
		for (int i = 31; i >= 0; i--)
		begin
			bit_cycle(w[i], !(op == OP_READ && i < 18), s);
			if (i < 16)
				rd[i] = s;
		end
		@(posedge ref_clk_i);
		mdc_o <= 1'b0;
		mdio_oe_o <= 1'b0;
	endtask : xfer
endmodule : pmcs_mgmt_master

// ---- verification/phy_mgmt_control_status_regs_tb_top.sv ----
`timescale 1ns/1ps
module phy_mgmt_control_status_regs_tb_top;
	import pmcs_pkg::*;
	logic ref_clk_i, reset_i, mdc_i, mdio_i, mdio_o, mdio_oe_o;
	logic [4:0] phy_address_straps_i;
	logic link_fail_i, jabber_i, interrupt_detect_i, partner_remote_fault_i;
	logic negotiation_ack_done_i, transceiver_reset_o, loopback_enable_o;
	logic speed_100_o, negotiation_enable_o, powerdown_enable_o;
	logic controller_if_disable_o, negotiation_restart_o, duplex_select_o;
	logic collision_test_enable_o, m_o, m_oe;
	logic [15:0] rd, got, d;
	logic [31:0] seed;
	int miscompares, checks, cyc;
	// Pulled up while nobody drives
	assign mdio_i = mdio_oe_o ? mdio_o : (m_oe ? m_o : 1'b1);
	pmcs_mgmt_regs uut (.*);
	pmcs_mgmt_master mst (.ref_clk_i(ref_clk_i), .line_i(mdio_i),
		.mdc_o(mdc_i), .mdio_o(m_o), .mdio_oe_o(m_oe));
	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	function automatic logic [15:0] pins(input logic [15:0] v);
		return {9'h000, v[14:10], v[8:7]};
	endfunction : pins
	task automatic chk(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic rdchk(input string what, input logic [4:0] ra,
		input logic [15:0] exp);
		mst.xfer(OP_READ, phy_address_straps_i, ra, 16'h0000, 32, rd);
		chk(what, rd, exp);
	endtask : rdchk
	task automatic wr(input logic [4:0] ra, input logic [15:0] v);
		mst.xfer(OP_WRITE, phy_address_straps_i, ra, v, 32, rd);
	endtask : wr
	task automatic do_reset(input logic [4:0] straps);
		phy_address_straps_i <= straps;
		reset_i <= 1'b1;
		repeat (16) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		repeat (8) @(posedge ref_clk_i);
	endtask : do_reset
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			miscompares++;
			close_out();
		end
	end
	initial
	begin
		reset_i = 1'b1;
		phy_address_straps_i = 5'h1f;
		link_fail_i = 1'b1;
		jabber_i = 1'b0;
		interrupt_detect_i = 1'b0;
		partner_remote_fault_i = 1'b0;
		negotiation_ack_done_i = 1'b0;
		seed = 32'd78466;
		@(posedge ref_clk_i);
		do_reset(5'h1f);
		rdchk("ctl dflt", PHY_CONTROL_ADDR, 16'h3400);
		seed = xs(seed);
		do_reset(seed[4:0] == 5'h1f ? 5'h0a : seed[4:0]);
		rdchk("ctl dflt", PHY_CONTROL_ADDR, 16'h3000);
		$display("test reset done");
		// Bits 15 and 9 are kept for their own tests
		for (int k = 0; k < 8; k++)
		begin
			seed = xs(seed);
			d = k == 0 ? 16'h7dff : (k == 1 ? 16'h0000 : seed[15:0] & 16'h7dff);
			wr(PHY_CONTROL_ADDR, d);
			repeat (4) @(posedge ref_clk_i);
			got = {9'h000, loopback_enable_o, speed_100_o, negotiation_enable_o,
				powerdown_enable_o, controller_if_disable_o, duplex_select_o,
				collision_test_enable_o};
			chk("ctl pins", got, pins(d));
			rdchk("ctl", PHY_CONTROL_ADDR, d & 16'h7d80);
		end
		wr(PHY_CONTROL_ADDR, 16'h1200);
		repeat (4) @(posedge ref_clk_i);
		chk("restart pin", {15'h0000, negotiation_restart_o}, 16'h0001);
		rdchk("restart", PHY_CONTROL_ADDR, 16'h1000);
		// Other bits of a reset write are dropped
		wr(PHY_CONTROL_ADDR, 16'hc980);
		repeat (4) @(posedge ref_clk_i);
		chk("reset pin", {15'h0000, transceiver_reset_o}, 16'h0001);
		rdchk("after reset", PHY_CONTROL_ADDR, 16'h3000);
		$display("test control done");
		rdchk("status", PHY_BASIC_STATUS_ADDR, 16'h7809);
		link_fail_i <= 1'b0;
		rdchk("link 1st", PHY_BASIC_STATUS_ADDR, 16'h7809);
		rdchk("link now", PHY_BASIC_STATUS_ADDR, 16'h780d);
		// One-cycle events must survive until read
		for (int k = 0; k < 3; k++)
		begin
			{partner_remote_fault_i, interrupt_detect_i, jabber_i} <= 3'b001 << k;
			@(posedge ref_clk_i);
			{partner_remote_fault_i, interrupt_detect_i, jabber_i} <= 3'b000;
			d = k == 0 ? 16'h780f : 16'h781d;
			rdchk("latched", PHY_BASIC_STATUS_ADDR, d);
			rdchk("cleared", PHY_BASIC_STATUS_ADDR, 16'h780d);
		end
		link_fail_i <= 1'b1;
		@(posedge ref_clk_i);
		link_fail_i <= 1'b0;
		rdchk("link drop", PHY_BASIC_STATUS_ADDR, 16'h7809);
		negotiation_ack_done_i <= 1'b1;
		wr(PHY_BASIC_STATUS_ADDR, 16'h0000);
		rdchk("ack", PHY_BASIC_STATUS_ADDR, 16'h782d);
		$display("test status done");
		wr(PHY_IDENTIFIER_HIGH_ADDR, 16'ha5a5);
		rdchk("id", PHY_IDENTIFIER_HIGH_ADDR, ORG_ID_HIGH);
		// One preamble bit short: the line stays with the pull-up
		mst.xfer(OP_READ, phy_address_straps_i, PHY_IDENTIFIER_HIGH_ADDR,
			16'h0000, 31, rd);
		chk("short pre", rd, 16'hffff);
		$display("test id done");
		close_out();
	end
endmodule : phy_mgmt_control_status_regs_tb_top
